// file: src/pcs_pkg.sv
package pcs_pkg;

   // -------------------------------------------------------------------
   // Register map (byte addresses, one aligned word each).
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_INT_STAT = 8'h04;
   localparam logic [7:0] ADDR_INT_MASK = 8'h08;
   localparam logic [7:0] ADDR_OPTIONS = 8'h0c;
   localparam logic [7:0] ADDR_FRAMING = 8'h10;
   localparam logic [7:0] ADDR_ALT_MASK = 8'h14;
   localparam logic [7:0] ADDR_CFG_DATA = 8'h18;

   // -------------------------------------------------------------------
   // Addressing constants.
   // -------------------------------------------------------------------
   localparam logic [4:0] CONFIG_ADDR = 5'h1f;
   localparam logic [4:0] MAX_NODE_ADDR = 5'h1e;
   localparam int NUM_BUTTONS = 24;

   // -------------------------------------------------------------------
   // Timing constants.
   // -------------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int COMM_FAIL_S = 12;
   localparam longint COMM_FAIL_CYC = longint'(COMM_FAIL_S) * longint'(CLK_HZ);
   localparam int FLASH_HZ = 4;
   localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);

   // -------------------------------------------------------------------
   // Field positions.
   // -------------------------------------------------------------------
   localparam int OPT_SEP = 0;
   localparam int OPT_FORCE = 1;
   localparam int OPT_FLASH = 2;
   localparam int OPT_MULTI = 3;
   localparam int INT_TIMEOUT = 0;
   localparam int INT_RESUME = 1;
   localparam int INT_CFG = 2;
   localparam int INT_W = 3;

   // Parity selections of the serial framing.
   typedef enum logic [1:0] {
      PCS_PAR_NONE,
      PCS_PAR_EVEN,
      PCS_PAR_ODD
   } pcs_parity_t;

   // Serial framing settings.
   typedef struct packed {
      logic eight_bits;
      pcs_parity_t parity;
      logic two_stop;
   } pcs_framing_t;

   // Option settings held for normal operation.
   typedef struct packed {
      logic multi_module;
      logic flash_en;
      logic force_en;
      logic led_sep;
   } pcs_options_t;

   localparam pcs_framing_t FRAMING_RST = '{eight_bits: 1'b1, parity: PCS_PAR_NONE,
                                            two_stop: 1'b0};

   // Stop bit count actually used: two only when the combination allows it.
   function automatic logic pcs_two_stop_ok(input pcs_framing_t f);
      return f.two_stop & ~(f.eight_bits & (f.parity != PCS_PAR_NONE));
   endfunction : pcs_two_stop_ok

endpackage : pcs_pkg

// file: src/pcs_comm_watchdog.sv
`timescale 1ns/1ns
module pcs_comm_watchdog #(
   parameter longint FAIL_CYC = pcs_pkg::COMM_FAIL_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic kick,
   output logic failed,
   output logic flash_phase
);

   logic [31:0] cnt_r;
   logic [31:0] flash_cnt_r;
   logic failed_r;
   logic phase_r;
   wire logic expired = (cnt_r >= 32'(FAIL_CYC - 1));
   wire logic half_done = (flash_cnt_r == 32'(pcs_pkg::FLASH_HALF_CYC - 1));

   // Silence timer; any good message restarts it and clears the alarm.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 32'h0;
         failed_r <= 1'b0;
      end else if (!enable || kick) begin
         cnt_r <= 32'h0;
         failed_r <= 1'b0;
      end else if (expired) begin
         failed_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   // Rapid flash divider, only running while the alarm stands.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_r <= 32'h0;
         phase_r <= 1'b0;
      end else if (!failed_r) begin
         flash_cnt_r <= 32'h0;
         phase_r <= 1'b0;
      end else if (half_done) begin
         flash_cnt_r <= 32'h0;
         phase_r <= ~phase_r;
      end else begin
         flash_cnt_r <= flash_cnt_r + 32'h1;
      end
   end

   assign failed = failed_r;
   assign flash_phase = phase_r;

endmodule : pcs_comm_watchdog

// file: src/pcs_supervisor.sv
`timescale 1ns/1ns
module pcs_supervisor #(
   parameter longint FAIL_CYC = pcs_pkg::COMM_FAIL_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] addr_sw,
   input wire logic [4:0] msg_addr,
   input wire logic msg_ok,
   input wire logic cfg_byte_valid,
   input wire logic [7:0] cfg_byte,
   input wire logic [23:0] button_state,
   input wire logic [23:0] host_lamp,
   output logic [23:0] led_drive,
   output logic config_mode,
   output logic addr_match,
   output logic two_stop_used,
   output logic hex_protocol,
   output logic [1:0] plc_regs_extra,
   output logic irq
);

   // ------------------------------------------------------------------
   // Power-up address capture.
   // ------------------------------------------------------------------
   logic [4:0] node_addr_r;
   logic cfg_mode_r;
   logic captured_r;

   // The switches are caught once after reset release, never under reset.
   wire logic [4:0] sw_addr = addr_sw[4:0]; // weights 1..16, sixth ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         node_addr_r <= 5'h0;
         cfg_mode_r <= 1'b0;
         captured_r <= 1'b0;
      end else if (!captured_r) begin
         node_addr_r <= sw_addr;
         cfg_mode_r <= (sw_addr == pcs_pkg::CONFIG_ADDR);
         captured_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------------
   pcs_pkg::pcs_options_t opt_r;
   pcs_pkg::pcs_framing_t frm_r;
   logic [23:0] alt_r;
   logic [7:0] cfg_last_r;
   logic [2:0] int_stat_r;
   logic [2:0] int_mask_r;

   wire logic wr_en = psel & penable & pwrite;
   wire logic sel_stat = (paddr == pcs_pkg::ADDR_STATUS);
   wire logic sel_int = (paddr == pcs_pkg::ADDR_INT_STAT);
   wire logic sel_mask = (paddr == pcs_pkg::ADDR_INT_MASK);
   wire logic sel_opt = (paddr == pcs_pkg::ADDR_OPTIONS);
   wire logic sel_frm = (paddr == pcs_pkg::ADDR_FRAMING);
   wire logic sel_alt = (paddr == pcs_pkg::ADDR_ALT_MASK);
   wire logic sel_cfg = (paddr == pcs_pkg::ADDR_CFG_DATA);
   wire logic mapped = sel_stat | sel_int | sel_mask | sel_opt | sel_frm | sel_alt | sel_cfg;

   // Configuration writes only land in download mode; otherwise the stored
   // setup stays frozen so a stray host write cannot alter a live panel.
   wire logic cfg_wr = wr_en & cfg_mode_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_r <= '0;
         frm_r <= pcs_pkg::FRAMING_RST;
         alt_r <= 24'h0;
      end else if (cfg_wr) begin
         if (sel_opt) opt_r <= pcs_pkg::pcs_options_t'(pwdata[3:0]);
         if (sel_frm) frm_r <= pcs_pkg::pcs_framing_t'(pwdata[3:0]);
         if (sel_alt) alt_r <= pwdata[23:0];
      end
   end

   // Bytes arriving on the serial link in download mode are kept too.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_last_r <= 8'h0;
      end else if (cfg_mode_r && cfg_byte_valid) begin
         cfg_last_r <= cfg_byte;
      end
   end

   // ------------------------------------------------------------------
   // Link supervision.
   // ------------------------------------------------------------------
   wire logic addr_in_range = (node_addr_r <= pcs_pkg::MAX_NODE_ADDR);
   wire logic good_msg = msg_ok & ~cfg_mode_r & addr_in_range & (msg_addr == node_addr_r);
   logic wd_failed;
   logic wd_phase;
   logic wd_failed_d_r;

   pcs_comm_watchdog #(
      .FAIL_CYC(FAIL_CYC)
   ) u_wd (
      .pclk(pclk),
      .presetn(presetn),
      .enable(captured_r & ~cfg_mode_r),
      .kick(good_msg),
      .failed(wd_failed),
      .flash_phase(wd_phase)
   );

   // ------------------------------------------------------------------
   // Interrupt status: set wins over a write-one clear.
   // ------------------------------------------------------------------
   wire logic [2:0] int_set = {cfg_mode_r & cfg_byte_valid,
                               wd_failed_d_r & ~wd_failed,
                               wd_failed & ~wd_failed_d_r};
   wire logic [2:0] int_clr = (wr_en & sel_int) ? pwdata[2:0] : 3'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= 3'h0;
         int_mask_r <= 3'h0;
         wd_failed_d_r <= 1'b0;
      end else begin
         wd_failed_d_r <= wd_failed;
         int_stat_r <= (int_stat_r & ~int_clr) | int_set;
         if (wr_en && sel_mask) int_mask_r <= pwdata[2:0];
      end
   end
   assign irq = |(int_stat_r & int_mask_r);

   // ------------------------------------------------------------------
   // LED drive.
   // ------------------------------------------------------------------
   logic [23:0] led_r;
   // Outside a link failure (all LEDs flash), alternate buttons show host lamps; momentary ones do so only
   // with separation on, otherwise they mirror the button locally.
   wire logic [23:0] led_norm = (opt_r.led_sep ? host_lamp : button_state) & ~alt_r
                                | (host_lamp & alt_r);
   wire logic [23:0] led_sel = wd_failed ? {24{wd_phase}} : led_norm;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         led_r <= 24'h0;
      end else begin
         led_r <= led_sel;
      end
   end
   assign led_drive = led_r;

   // ------------------------------------------------------------------
   // Derived settings and status outputs.
   // ------------------------------------------------------------------
   assign config_mode = cfg_mode_r;
   assign addr_match = good_msg;
   assign two_stop_used = pcs_pkg::pcs_two_stop_ok(frm_r);
   // multi_module changes neither framing nor PLC type; hex_protocol is always high, so the module always talks hex.
   assign hex_protocol = opt_r.multi_module | ~opt_r.flash_en | 1'b1;
   assign plc_regs_extra = opt_r.flash_en ? 2'h2 : 2'h0;

   // ------------------------------------------------------------------
   // APB read path: zero wait state, unmapped addresses flag an error.
   // ------------------------------------------------------------------
   wire logic [31:0] status_word = {20'h0, wd_failed, two_stop_used, cfg_mode_r,
                                    addr_in_range, 3'h0, node_addr_r};
   wire logic [31:0] rd_mux = sel_stat ? status_word :
                              sel_int ? {29'h0, int_stat_r} :
                              sel_mask ? {29'h0, int_mask_r} :
                              sel_opt ? {28'h0, opt_r} :
                              sel_frm ? {28'h0, frm_r} :
                              sel_alt ? {8'h0, alt_r} :
                              sel_cfg ? {24'h0, cfg_last_r} : 32'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

endmodule : pcs_supervisor

// file: tb/pcs_host_model.sv
`timescale 1ns/1ns
// Far side of the serial link: hands the block checked messages and config bytes.
module pcs_host_model (
   input wire logic pclk,
   output logic [4:0] msg_addr,
   output logic msg_ok,
   output logic cfg_byte_valid,
   output logic [7:0] cfg_byte
);
   // Idle link at time zero.
   initial begin
      msg_addr = 5'h00;
      msg_ok = 1'b0;
      cfg_byte_valid = 1'b0;
      cfg_byte = 8'h00;
   end
   // One good message; a gap of idle cycles models a slow host.
   task automatic send_msg(input logic [4:0] a, input int gap);
      @(posedge pclk);
      msg_addr <= a;
      msg_ok <= 1'b1;
      @(posedge pclk);
      msg_ok <= 1'b0;
      msg_addr <= ~a; // A released field must never look valid.
      repeat (gap) @(posedge pclk);
   endtask : send_msg
   // Configuration uses the same link as normal traffic.
   task automatic send_cfg(input logic [7:0] b);
      @(posedge pclk);
      cfg_byte <= b;
      cfg_byte_valid <= 1'b1;
      @(posedge pclk);
      cfg_byte_valid <= 1'b0;
      cfg_byte <= ~b;
   endtask : send_cfg
endmodule : pcs_host_model

// file: tb/pcs_supervisor_props.sv
`timescale 1ns/1ns
// Port checker; the silence window keeps margins since the timer start edge is not fixed.
module pcs_supervisor_props #(
   parameter longint FAIL_CYC = 200
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] addr_sw,
   input wire logic [4:0] msg_addr,
   input wire logic msg_ok,
   input wire logic [23:0] button_state,
   input wire logic [23:0] led_drive,
   input wire logic config_mode,
   input wire logic addr_match,
   input wire logic hex_protocol,
   input wire logic [1:0] plc_regs_extra
);
   logic [1:0] up_r;
   logic [4:0] sw_r;
   longint sil_r;
   wire logic up = up_r[1];
   wire logic quiet = sil_r > FAIL_CYC + 4;
   wire logic live = sil_r >= 2 && sil_r < FAIL_CYC - 4;
   // Time since reset, captured switches, and time since the last accepted message.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_r <= 2'h0;
         sw_r <= 5'h00;
         sil_r <= 0;
      end else begin
         if (!up_r[1]) up_r <= up_r + 2'h1;
         if (up_r == 2'h0) sw_r <= addr_sw[4:0];
         sil_r <= addr_match ? 0 : sil_r + 1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_mode; up |-> config_mode == (sw_r == 5'h1f); endproperty
   a_mode: assert property (p_mode)
      else $error("config mode disagrees with switches");
   property p_acc; up && addr_match |-> msg_ok && msg_addr <= 5'h1e && msg_addr == sw_r; endproperty
   a_acc: assert property (p_acc)
      else $error("accepted a message not for this module");
   property p_take; up && !config_mode && msg_ok && msg_addr == sw_r |-> addr_match; endproperty
   a_take: assert property (p_take)
      else $error("own message not accepted");
   property p_cfg; config_mode |-> !addr_match; endproperty
   a_cfg: assert property (p_cfg)
      else $error("message accepted in config mode");
   property p_hex; hex_protocol; endproperty
   a_hex: assert property (p_hex)
      else $error("hex protocol low");
   property p_plc; !plc_regs_extra[0]; endproperty
   a_plc: assert property (p_plc)
      else $error("odd count of extra host registers");
   property p_flash; up && !config_mode && quiet |-> led_drive == 24'h0; endproperty
   a_flash: assert property (p_flash)
      else $error("leds not in flash phase after silence");
   property p_led; up && !config_mode && live |-> led_drive == $past(button_state); endproperty
   a_led: assert property (p_led)
      else $error("leds do not follow buttons");
endmodule : pcs_supervisor_props
bind pcs_supervisor pcs_supervisor_props #(.FAIL_CYC(FAIL_CYC)) u_props (.pclk, .presetn,
   .addr_sw, .msg_addr, .msg_ok, .button_state, .led_drive, .config_mode, .addr_match,
   .hex_protocol, .plc_regs_extra);

// file: tb/test_panel_config_address_supervisor.sv
`timescale 1ns/1ns
module test_panel_config_address_supervisor;
   localparam longint FAIL = 200;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, msg_ok, cfg_byte_valid, irq;
   logic config_mode, addr_match, two_stop_used, hex_protocol, err_q, ia;
   logic [7:0] paddr, cfg_byte;
   logic [31:0] pwdata, prdata, rd_q;
   logic [5:0] addr_sw;
   logic [4:0] msg_addr;
   logic [23:0] button_state, host_lamp, led_drive;
   logic [1:0] plc_regs_extra;
   int n_checks = 0, miscompares = 0, cycles = 0;
   logic [47:0] rows [4] = '{48'h0, {2{24'hffffff}}, {2{24'h800001}}, {2{24'h5a5a5a}}};
   logic [4:0] fr [4] = '{5'h16, 5'h03, 5'h1a, 5'h13}; // framing word, then used stop
   pcs_supervisor #(.FAIL_CYC(FAIL)) DUT (.*);
   pcs_host_model HOST (.pclk, .msg_addr, .msg_ok, .cfg_byte_valid, .cfg_byte);
   always #5 pclk = ~pclk;
   // Cut a hang short.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // APB transfer held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_q, exp);
   endtask : rd_chk
   task automatic do_reset(input logic [5:0] sw);
      presetn <= 1'b0;
      addr_sw <= sw;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
   endtask : do_reset
   // Main sequence: normal mode at address 14 with the spare switch set, then config mode.
   initial begin
      {pclk, psel, penable, pwrite, paddr, pwdata, button_state, host_lamp} = '0;
      do_reset(6'h2e);
      rd_chk(pcs_pkg::ADDR_STATUS, 32'h10e);
      HOST.send_msg(5'h0e, 0);
      for (int i = 0; i < 4; i++) begin
         button_state <= rows[i][47:24];
         repeat (2) @(posedge pclk);
         chk({8'h0, led_drive}, {8'h0, rows[i][23:0]});
      end
      apb(1'b1, pcs_pkg::ADDR_OPTIONS, 32'hf);
      rd_chk(pcs_pkg::ADDR_OPTIONS, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err_q}, 32'h1);
      repeat (FAIL + 20) @(posedge pclk);
      chk({8'h0, led_drive}, 32'h0);
      rd_chk(pcs_pkg::ADDR_STATUS, 32'h90e);
      rd_chk(pcs_pkg::ADDR_INT_STAT, 32'h1);
      apb(1'b1, pcs_pkg::ADDR_INT_MASK, 32'h0);
      @(posedge pclk);
      ia = irq;
      apb(1'b1, pcs_pkg::ADDR_INT_MASK, 32'h7);
      @(posedge pclk);
      chk({31'h0, ia ^ irq}, 32'h1);
      apb(1'b1, pcs_pkg::ADDR_INT_STAT, 32'h7);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      HOST.send_msg(5'h14, 2);
      chk({8'h0, led_drive}, 32'h0);
      HOST.send_msg(5'h0e, 2);
      chk({8'h0, led_drive}, 32'h5a5a5a);
      rd_chk(pcs_pkg::ADDR_INT_STAT, 32'h2);
      do_reset(6'h1f);
      chk({31'h0, config_mode}, 32'h1);
      HOST.send_cfg(8'ha5);
      rd_chk(pcs_pkg::ADDR_CFG_DATA, 32'ha5);
      rd_chk(pcs_pkg::ADDR_INT_STAT, 32'h4);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, pcs_pkg::ADDR_FRAMING, {28'h0, fr[i][4:1]});
         @(posedge pclk);
         chk({31'h0, two_stop_used}, {31'h0, fr[i][0]});
      end
      apb(1'b1, pcs_pkg::ADDR_OPTIONS, 32'h4);
      @(posedge pclk);
      chk({30'h0, plc_regs_extra}, 32'h2);
      apb(1'b1, pcs_pkg::ADDR_OPTIONS, 32'h1);
      host_lamp <= 24'h00ff00;
      button_state <= 24'h0f0f0f;
      repeat (3) @(posedge pclk);
      chk({8'h0, led_drive}, 32'h00ff00);
      chk({31'h0, hex_protocol}, 32'h1);
      results();
   end
endmodule : test_panel_config_address_supervisor
